// >>> shared_regs_pkg.sv
// Constants and types for the shared register bank with lane select
// What this block does
// RULE1 - Bit 6 of 0x04 resets shared registers, self-clears
// RULE2 - Bit 5 of 0x04 resets master-mode logic, self-clears
// RULE3 - Bit 4 of 0x04 forces EEPROM config load
// RULE4 - Bit 7 of 0x05 disables automatic EEPROM load
// RULE5 - Bit 4 of 0x05 reads load done, default 1
// RULE6 - Bits 3..0 of 0x05 flag lane 0..3 interrupts
// RULE7 - Broadcast bit sends lane writes to all lanes
// RULE8 - Lane reads come from indexed lane only
// RULE9 - Lane space enable steers accesses to lanes
// RULE10 - Writes to 0xff always update lane select
// RULE11 - Lane select not readable, read undefined
// RULE12 - Host writes full byte, upper nibble zero
// RULE13 - Decode 0x00 shared, 0x04-7 lane, 0x0c-f broadcast
// RULE14 - Selection persists until lane select rewritten
// RULE15 - Writes to read-only bits are discarded
// RULE16 - Target address is 0x18 plus strap bits
// RULE17 - Self-clearing reset bits read back zero
`default_nettype none
package shared_regs_pkg;
    localparam logic [7:0] ADDR_STRAP    = 8'h00;
    localparam logic [7:0] ADDR_RSV_A    = 8'h02;
    localparam logic [7:0] ADDR_RSV_B    = 8'h03;
    localparam logic [7:0] ADDR_CTRL     = 8'h04;
    localparam logic [7:0] ADDR_STAT     = 8'h05;
    localparam logic [7:0] ADDR_RSV_C    = 8'h06;
    localparam logic [7:0] ADDR_RSV_D    = 8'h07;
    localparam logic [7:0] ADDR_LANE_SEL = 8'hff;
    localparam logic [7:0] RST_RSV_A     = 8'h00;
    localparam logic [7:0] RST_RSV_B     = 8'h00;
    localparam logic [7:0] RST_CTRL      = 8'h01;
    localparam logic [7:0] RST_STAT_RW   = 8'h00;
    localparam logic [7:0] RST_RSV_C     = 8'h00;
    localparam logic [7:0] RST_RSV_D     = 8'h05;
    localparam logic [7:0] RST_LANE_SEL  = 8'h00;
    localparam logic [7:0] UNDEF_READ    = 8'h00;
    localparam int CTRL_REGS_RST  = 6;
    localparam int CTRL_MAS_RST   = 5;
    localparam int CTRL_FORCE     = 4;
    localparam int STAT_DISABLE   = 7;
    localparam int STAT_DONE      = 4;
    localparam int SEL_BCAST      = 3;
    localparam int SEL_EN         = 2;
    localparam logic [7:0] CTRL_RW_MASK = 8'h9f;
    localparam logic [7:0] STAT_RW_MASK = 8'he0;
    localparam logic [6:0] BASE_ADDR    = 7'h18;
    localparam int NUM_LANES = 4;
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;
    typedef struct packed {
        logic [3:0] wr_en;
        logic [1:0] rd_lane;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } lane_req_t;
endpackage
`default_nettype wire

// >>> lane_select_decoder.sv
// Lane-select register and access steering between shared and lane sets
`default_nettype none
module lane_select_decoder
    import shared_regs_pkg::*;
(
    input  wire logic                      i_mclk,
    input  wire logic                      i_rstn,
    input  wire shared_regs_pkg::reg_req_t i_req,
    output logic                           o_lane_mode,
    output shared_regs_pkg::lane_req_t     o_lane_req,
    output logic                           o_shared_wr,
    output logic                           o_shared_rd,
    output logic                           o_sel_rd
);
    logic [7:0] sel_q;
    logic       is_sel;

    assign is_sel = (i_req.addr == ADDR_LANE_SEL);

    // Only the select write changes the target, so it persists [RULE14]
    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            sel_q <= RST_LANE_SEL;
        end else if (i_req.wr && is_sel) begin
            sel_q <= i_req.wdata; // [RULE10] [RULE12]
        end
    end

    assign o_lane_mode = sel_q[SEL_EN]; // [RULE9] [RULE13]

    always_comb begin
        o_lane_req         = '0;
        o_lane_req.addr    = i_req.addr;
        o_lane_req.wdata   = i_req.wdata;
        o_lane_req.rd_lane = sel_q[1:0]; // [RULE8]
        o_lane_req.rd      = i_req.rd && !is_sel && sel_q[SEL_EN];
        if (i_req.wr && !is_sel && sel_q[SEL_EN]) begin
            if (sel_q[SEL_BCAST]) begin
                o_lane_req.wr_en = '1; // [RULE7]
            end else begin
                o_lane_req.wr_en = 4'(1 << sel_q[1:0]);
            end
        end
    end

    assign o_shared_wr = i_req.wr && !is_sel && !sel_q[SEL_EN]; // [RULE9]
    assign o_shared_rd = i_req.rd && !is_sel && !sel_q[SEL_EN];
    assign o_sel_rd    = i_req.rd && is_sel; // [RULE11]
endmodule
`default_nettype wire

// >>> shared_regs_lane_select.sv
// Shared control/status registers of the four-lane retimer with lane steering
`default_nettype none
module shared_regs_lane_select
    import shared_regs_pkg::*;
(
    input  wire logic                      i_mclk,
    input  wire logic                      i_rstn,
    input  wire shared_regs_pkg::reg_req_t i_req,
    input  wire logic [3:0]                i_addr_strap,
    input  wire logic [3:0]                i_lane_irq,
    input  wire logic                      i_load_done,
    input  wire logic                      i_load_busy,
    input  wire logic [7:0]                i_lane_rdata,
    output shared_regs_pkg::lane_req_t     o_lane_req,
    output logic                           o_lane_mode,
    output logic [6:0]                     o_target_addr,
    output logic                           o_force_config_load,
    output logic                           o_auto_load_enable,
    output logic                           o_master_mode_logic_reset,
    output logic [7:0]                     o_rdata,
    output logic                           o_rvalid
);
    logic [7:0] ctrl_q;
    logic [7:0] stat_rw_q;
    logic [7:0] rsv_a_q;
    logic [7:0] rsv_b_q;
    logic [7:0] rsv_c_q;
    logic [7:0] rsv_d_q;
    logic [3:0] lane_irq_flag_q;
    logic       load_done_q;
    logic       shared_regs_reset;
    logic       master_reset_q;
    logic       shared_wr;
    logic       shared_rd;
    logic       sel_rd;
    logic [7:0] stat_rd;
    logic [7:0] shared_rd_d;

    lane_select_decoder u_dec (
        .i_mclk      (i_mclk),
        .i_rstn      (i_rstn),
        .i_req       (i_req),
        .o_lane_mode (o_lane_mode),
        .o_lane_req  (o_lane_req),
        .o_shared_wr (shared_wr),
        .o_shared_rd (shared_rd),
        .o_sel_rd    (sel_rd)
    );

    // Self-clearing bits are never stored, so they always read zero [RULE17]
    assign shared_regs_reset = shared_wr && (i_req.addr == ADDR_CTRL)
                               && i_req.wdata[CTRL_REGS_RST]; // [RULE1]

    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            master_reset_q <= 1'b0;
        end else begin
            master_reset_q <= shared_wr && (i_req.addr == ADDR_CTRL)
                              && i_req.wdata[CTRL_MAS_RST]; // [RULE2]
        end
    end

    // Shared register reset wins over a simultaneous write [RULE1]
    always_ff @(posedge i_mclk) begin
        if (!i_rstn || shared_regs_reset) begin
            ctrl_q    <= RST_CTRL;
            stat_rw_q <= RST_STAT_RW;
            rsv_a_q   <= RST_RSV_A;
            rsv_b_q   <= RST_RSV_B;
            rsv_c_q   <= RST_RSV_C;
            rsv_d_q   <= RST_RSV_D;
        end else if (shared_wr) begin
            case (i_req.addr)
                ADDR_CTRL:  ctrl_q    <= i_req.wdata & CTRL_RW_MASK; // [RULE17]
                ADDR_STAT:  stat_rw_q <= i_req.wdata & STAT_RW_MASK; // [RULE15]
                ADDR_RSV_A: rsv_a_q   <= i_req.wdata;
                ADDR_RSV_B: rsv_b_q   <= i_req.wdata;
                ADDR_RSV_C: rsv_c_q   <= i_req.wdata;
                ADDR_RSV_D: rsv_d_q   <= i_req.wdata;
                default:    ;
            endcase
        end
    end

    // Interrupt summary is sticky; a shared reset clears it [RULE6]
    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            lane_irq_flag_q <= '0;
        end else if (shared_regs_reset) begin
            // An event in the clearing cycle still lands
            lane_irq_flag_q <= i_lane_irq;
        end else begin
            lane_irq_flag_q <= lane_irq_flag_q | i_lane_irq;
        end
    end

    // Done is high from reset; a running load drops it until finished [RULE5]
    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            load_done_q <= 1'b1;
        end else if (i_load_done) begin
            load_done_q <= 1'b1;
        end else if (i_load_busy) begin
            load_done_q <= 1'b0;
        end
    end

    always_comb begin
        stat_rd                  = stat_rw_q;
        stat_rd[STAT_DONE]       = load_done_q;
        // Lane 0 sits at bit 3, lane 3 at bit 0 [RULE6]
        for (int i = 0; i < NUM_LANES; i++) begin
            stat_rd[NUM_LANES-1-i] = lane_irq_flag_q[i];
        end
    end

    always_comb begin
        case (i_req.addr)
            ADDR_STRAP: shared_rd_d = {i_addr_strap, 4'h0}; // [RULE16]
            ADDR_RSV_A: shared_rd_d = rsv_a_q;
            ADDR_RSV_B: shared_rd_d = rsv_b_q;
            ADDR_CTRL:  shared_rd_d = ctrl_q;
            ADDR_STAT:  shared_rd_d = stat_rd;
            ADDR_RSV_C: shared_rd_d = rsv_c_q;
            ADDR_RSV_D: shared_rd_d = rsv_d_q;
            default:    shared_rd_d = UNDEF_READ;
        endcase
    end

    // Read data registered one cycle after the request
    // Lane sets answer in the request cycle, so every read has one latency
    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            o_rdata  <= '0;
            o_rvalid <= 1'b0;
        end else begin
            o_rvalid <= i_req.rd;
            if (shared_rd) begin
                o_rdata <= shared_rd_d;
            end else if (sel_rd) begin
                o_rdata <= UNDEF_READ; // [RULE11]
            end else if (o_lane_req.rd) begin
                o_rdata <= i_lane_rdata; // [RULE8]
            end
        end
    end

    assign o_target_addr             = 7'(BASE_ADDR + {3'h0, i_addr_strap}); // [RULE16]
    assign o_force_config_load       = ctrl_q[CTRL_FORCE]; // [RULE3]
    assign o_auto_load_enable        = !stat_rw_q[STAT_DISABLE]; // [RULE4]
    assign o_master_mode_logic_reset = master_reset_q; // [RULE2]
endmodule
`default_nettype wire

// >>> regs_monitor.sv
// Port checker for the shared register bank
`default_nettype none
module regs_monitor (
    input wire logic                       i_mclk,
    input wire logic                       i_rstn,
    input wire shared_regs_pkg::reg_req_t  i_req,
    input wire logic [3:0]                 i_addr_strap,
    input wire shared_regs_pkg::lane_req_t o_lane_req,
    input wire logic                       o_lane_mode,
    input wire logic [6:0]                 o_target_addr,
    input wire logic                       o_master_mode_logic_reset
);
    timeunit 1ns;
    timeprecision 1ps;
    import shared_regs_pkg::*;
    logic [7:0] sel_q;
    logic       sel_wr;
    logic       lane_wr;
    // Own copy of the select byte, since it cannot be read back
    always_ff @(posedge i_mclk) begin
        if (!i_rstn) sel_q <= 8'h00;
        else if (sel_wr) sel_q <= i_req.wdata;
    end
    assign sel_wr = i_req.wr && i_req.addr == ADDR_LANE_SEL;
    assign lane_wr = i_req.wr && !sel_wr && sel_q[SEL_EN];
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rstn);
    bcast_fanout_a: assert property (lane_wr && sel_q[3] |-> o_lane_req.wr_en == 4'hf)
        else $error("broadcast missed a lane");
    single_lane_a: assert property (lane_wr && !sel_q[3] |-> o_lane_req.wr_en == 4'h1 << sel_q[1:0])
        else $error("wrong lane strobe");
    lane_read_a: assert property (
            i_req.rd && sel_q[2] && i_req.addr != ADDR_LANE_SEL
            |-> o_lane_req.rd && o_lane_req.rd_lane == sel_q[1:0])
        else $error("wrong read lane");
    shared_space_a: assert property (!sel_q[2] |-> o_lane_req.wr_en == 4'h0 && !o_lane_req.rd)
        else $error("lane access in shared mode");
    sel_write_a: assert property (
            sel_wr |-> o_lane_req.wr_en == 4'h0 ##1 o_lane_mode == $past(i_req.wdata[SEL_EN]))
        else $error("select write misrouted");
    sel_hold_a: assert property (!sel_wr |=> $stable(o_lane_mode))
        else $error("lane mode changed alone");
    target_addr_a: assert property (o_target_addr == BASE_ADDR + {3'h0, i_addr_strap})
        else $error("bad target address");
    master_pulse_a: assert property (
            i_req.wr && !sel_q[2] && i_req.addr == ADDR_CTRL && i_req.wdata[CTRL_MAS_RST]
            |=> o_master_mode_logic_reset ##1 !o_master_mode_logic_reset)
        else $error("bad master reset pulse");
    cover property (lane_wr && sel_q[3]);
    cover property (o_master_mode_logic_reset);
    cover property (i_req.rd && sel_q[2]);
endmodule
bind shared_regs_lane_select regs_monitor mon_u (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_req(i_req),
    .i_addr_strap(i_addr_strap), .o_lane_req(o_lane_req), .o_lane_mode(o_lane_mode),
    .o_target_addr(o_target_addr), .o_master_mode_logic_reset(o_master_mode_logic_reset));
`default_nettype wire

// >>> smb_host_model.sv
// Behavioural host issuing single-byte register accesses
`default_nettype none
module smb_host_model (
    input  wire logic                       i_mclk,
    input  wire shared_regs_pkg::lane_req_t i_lane_req,
    input  wire logic [7:0]                 i_rdata,
    input  wire logic                       i_rvalid,
    output var logic [7:0]                  o_lane_rdata,
    output var shared_regs_pkg::reg_req_t   o_req
);
    timeunit 1ns;
    timeprecision 1ps;
    import shared_regs_pkg::*;
    lane_req_t seen;
    // Each lane answers with its own index, so a wrong lane shows
    always_comb o_lane_rdata = {4'hc, 2'h0, i_lane_req.rd_lane};
    initial o_req = '0;
    always @(posedge i_mclk) if (o_req.wr || o_req.rd) seen <= i_lane_req;
    // Released address lines carry the inverse; a write also inverts its data byte, a read holds it
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_mclk) o_req = '{1'b1, 1'b0, a, d}; // whole byte each time
        @(negedge i_mclk) o_req = '{1'b0, 1'b0, ~a, ~d};
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge i_mclk) o_req = '{1'b0, 1'b1, a, ~o_req.wdata};
        @(negedge i_mclk) d = i_rvalid ? i_rdata : 8'hxx;
        o_req = '{1'b0, 1'b0, ~a, o_req.wdata};
    endtask
endmodule
`default_nettype wire

// >>> testbench.sv
// Self-checking bench for the shared register bank
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import shared_regs_pkg::*;
    logic       i_mclk = 0, i_rstn = 0, ld_done = 0, ld_busy = 0, lmode, force_ld, auto_ld, mas, rvalid;
    logic [3:0] irq = 4'h0, strap = 4'h9;
    logic [6:0] taddr;
    logic [7:0] rdata, v, lrdata;
    reg_req_t   req;
    lane_req_t  lreq;
    int         err_total = 0, tests_run = 0;
    always #2 i_mclk = ~i_mclk;
    shared_regs_lane_select dut_u (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_req(req), .i_addr_strap(strap),
        .i_lane_irq(irq), .i_load_done(ld_done), .i_load_busy(ld_busy), .i_lane_rdata(lrdata),
        .o_lane_req(lreq), .o_lane_mode(lmode), .o_target_addr(taddr), .o_force_config_load(force_ld),
        .o_auto_load_enable(auto_ld), .o_master_mode_logic_reset(mas), .o_rdata(rdata), .o_rvalid(rvalid));
    smb_host_model host_u (.i_mclk(i_mclk), .i_lane_req(lreq), .i_rdata(rdata), .i_rvalid(rvalid),
        .o_lane_rdata(lrdata), .o_req(req));
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        host_u.rd(a, v);
        chk("rdata", e, v);
    endtask
    task automatic t_status();
        rchk(ADDR_CTRL, RST_CTRL);
        rchk(ADDR_RSV_D, RST_RSV_D);
        chk("taddr", 8'h21, {1'b0, taddr});
        @(negedge i_mclk) strap = 4'h6;
        rchk(ADDR_STRAP, 8'h60);
        chk("taddr", 8'h1e, {1'b0, taddr});
        host_u.wr(ADDR_STAT, 8'hff);
        chk("auto", 8'h00, {7'h0, auto_ld});
        @(negedge i_mclk) irq = 4'h3;
        @(negedge i_mclk) irq = 4'h0;
        rchk(ADDR_STAT, 8'hfc);
        ld_busy = 1;
        rchk(ADDR_STAT, 8'hec);
        ld_busy = 0;
        ld_done = 1;
        @(negedge i_mclk) ld_done = 0;
        rchk(ADDR_STAT, 8'hfc);
    endtask
    task automatic t_resets();
        host_u.wr(ADDR_CTRL, 8'h11);
        chk("force", 8'h01, {7'h0, force_ld});
        host_u.wr(ADDR_CTRL, 8'h31);
        chk("master", 8'h01, {7'h0, mas});
        rchk(ADDR_CTRL, 8'h11);
        host_u.wr(ADDR_CTRL, 8'h40);
        rchk(ADDR_CTRL, RST_CTRL);
        rchk(ADDR_STAT, 8'h10);
        chk("force", 8'h00, {7'h0, force_ld});
        chk("auto", 8'h01, {7'h0, auto_ld});
    endtask
    task automatic t_lanes();
        logic [7:0] s;
        for (int i = 0; i < 8; i++) begin
            s = {4'h0, i[2], 1'b1, i[1:0]}; // Upper nibble kept zero
            host_u.wr(ADDR_LANE_SEL, s);
            chk("sel_strobe", 8'h00, {4'h0, host_u.seen.wr_en});
            host_u.wr(8'h10, 8'h5a);
            chk("wr_en", i[2] ? 8'h0f : 8'h01 << i[1:0], {4'h0, host_u.seen.wr_en});
            chk("lane_addr", 8'h10, host_u.seen.addr);
            chk("lane_wdata", 8'h5a, host_u.seen.wdata);
            host_u.rd(8'h10, v);
            chk("rd_lane", {6'h01, i[1:0]}, {5'h0, host_u.seen.rd, host_u.seen.rd_lane});
            chk("lane_rdata", {6'h30, i[1:0]}, v);
        end
        host_u.wr(ADDR_LANE_SEL, 8'h00);
        chk("lmode", 8'h00, {7'h0, lmode});
        host_u.wr(ADDR_RSV_C, 8'h3c);
        rchk(ADDR_RSV_C, 8'h3c);
        rchk(ADDR_LANE_SEL, UNDEF_READ);
        host_u.wr(ADDR_STRAP, 8'hff);
        rchk(ADDR_STRAP, 8'h60);
    endtask
    task automatic close_out();
        if (err_total == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (2) @(negedge i_mclk);
        i_rstn = 1;
        t_status();
        t_resets();
        t_lanes();
        close_out();
    end
    // Whole run is under a hundred cycles
    initial begin
        #20000;
        err_total++;
        close_out();
    end
endmodule
`default_nettype wire
